// file: hdl/cie_pkg.sv
// Package of constants and types for the instruction slice execution unit.
package cie_pkg;
	typedef enum logic [4:0] {
		CIE_OP_NOP, CIE_OP_CCR_LOAD, CIE_OP_SR_STORE, CIE_OP_SR_LOAD, CIE_OP_USP_TO_AREG,
		CIE_OP_AREG_TO_USP, CIE_OP_CTRL_TO_GREG, CIE_OP_GREG_TO_CTRL, CIE_OP_ALT_WRITE,
		CIE_OP_ALT_READ, CIE_OP_SIGNED_MULTIPLY, CIE_OP_UNSIGNED_MULTIPLY, CIE_OP_DECIMAL_NEGATE, CIE_OP_NEG, CIE_OP_INVERT_WITH_BORROW,
		CIE_OP_OR, CIE_OP_ORI, CIE_OP_ORI_CCR, CIE_OP_ORI_SR, CIE_OP_PEA, CIE_OP_RESET,
		CIE_OP_QUICK, CIE_OP_MREG_STORE, CIE_OP_MREG_LOAD, CIE_OP_ROL, CIE_OP_ROR
	} cie_op_t;
	typedef enum logic [1:0] {CIE_MUL_W, CIE_MUL_L32, CIE_MUL_L64} cie_mul_t;
	typedef enum logic [1:0] {CIE_SZ_B, CIE_SZ_W, CIE_SZ_L} cie_size_t;
	localparam logic [15:0] CIE_SR_RST = 16'h2700;
	localparam int CIE_SR_S_BIT = 13;
	localparam int CIE_CCR_X_BIT = 4;
	localparam logic [31:0] CIE_USP_RST = 32'h00000000;
	localparam logic [31:0] CIE_SSP_RST = 32'h00000000;
	localparam logic [31:0] CIE_PEA_STEP = 32'h00000004;
	localparam logic [31:0] CIE_MREG_STEP = 32'h00000004;
	localparam logic [2:0] CIE_SFC_RST = 3'h0;
	localparam logic [2:0] CIE_DFC_RST = 3'h0;
	localparam logic [11:0] CIE_CR_SFC = 12'h000;
	localparam logic [11:0] CIE_CR_DFC = 12'h001;
	localparam logic [11:0] CIE_CR_USP = 12'h800;
	localparam logic [11:0] CIE_CR_VBR = 12'h801;
	localparam int CIE_RESET_CYCLES = 124;
	localparam logic [7:0] CIE_RESET_CNT = 8'(CIE_RESET_CYCLES);
	localparam int CIE_IRQ_TRAP = 0;
	localparam int CIE_IRQ_DONE = 1;
	localparam int CIE_IRQ_RESET = 2;
	localparam logic [2:0] CIE_INT_RST = 3'h0;
	localparam logic [3:0] CIE_ADR_STATUS = 4'h0;
	localparam logic [3:0] CIE_ADR_SR = 4'h1;
	localparam logic [3:0] CIE_ADR_USP = 4'h2;
	localparam logic [3:0] CIE_ADR_MASK = 4'h3;
	localparam logic [3:0] CIE_ADR_SFC = 4'h4;
	localparam logic [3:0] CIE_ADR_DFC = 4'h5;
	localparam logic [3:0] CIE_ADR_VBR = 4'h6;
	localparam logic [3:0] CIE_ADR_SSP = 4'h7;
endpackage

// file: hdl/cie_exec.sv
// Execution unit for the status, stack, control, arithmetic, OR, push, reset and rotate slice.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module cie_exec
	import cie_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic op_valid,
	input var cie_op_t op_code,
	input var cie_size_t op_size,
	input var cie_mul_t op_mul_form,
	input wire logic [31:0] op_src,
	input wire logic [31:0] op_dst,
	input wire logic [31:0] op_dst_hi,
	input wire logic [31:0] op_imm,
	input wire logic [11:0] op_ctrl_sel,
	input wire logic [15:0] op_reg_list,
	input wire logic [31:0] op_addr,
	output logic op_busy,
	output logic res_valid,
	output logic [31:0] res_data,
	output logic [31:0] res_data_hi,
	output logic res_hi_valid,
	output logic res_trap,
	output logic mem_we,
	output logic mem_re,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	output logic [2:0] mem_fc,
	output logic [3:0] mem_reg_idx,
	output logic ext_reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [31:0] reg_rdata,
	output logic irq
);
	typedef enum logic [1:0] {CIE_ST_IDLE, CIE_ST_MREG, CIE_ST_RESET} cie_state_t;

	cie_state_t state_ff, nxt_state;
	logic [15:0] sr_ff, nxt_sr;
	logic [31:0] usp_ff, nxt_usp, ssp_ff, nxt_ssp, vbr_ff, nxt_vbr;
	logic [2:0] sfc_ff, nxt_sfc, dfc_ff, nxt_dfc;
	logic [15:0] list_ff, nxt_list;
	logic mreg_load_ff, nxt_mreg_load;
	logic [7:0] rst_cnt_ff, nxt_rst_cnt;
	logic res_valid_ff, nxt_res_valid, res_trap_ff, nxt_res_trap, res_hi_ff, nxt_res_hi;
	logic [31:0] res_data_ff, nxt_res_data, res_hi_data_ff, nxt_res_hi_data;
	logic mem_we_ff, nxt_mem_we, mem_re_ff, nxt_mem_re;
	logic [31:0] mem_addr_ff, nxt_mem_addr, mem_wdata_ff, nxt_mem_wdata;
	logic [2:0] mem_fc_ff, nxt_mem_fc;
	logic [3:0] mem_idx_ff, nxt_mem_idx;
	logic [2:0] int_stat_ff, nxt_int_stat, int_mask_ff, nxt_int_mask;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [2:0] events;
	logic supv, priv_op;

	function automatic logic [31:0] size_mask(input cie_size_t sz);
		unique case (sz)
			CIE_SZ_B: size_mask = 32'h000000FF;
			CIE_SZ_W: size_mask = 32'h0000FFFF;
			default: size_mask = 32'hFFFFFFFF;
		endcase
	endfunction

	// Keeps the untouched upper part of a register when a byte or word is written.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
		input cie_size_t sz);
		merge = (old & ~size_mask(sz)) | (val & size_mask(sz));
	endfunction

	function automatic logic [31:0] rotate(input logic [31:0] v, input logic [5:0] cnt,
		input cie_size_t sz, input logic left);
		logic [31:0] r;
		int w;
		r = v;
		w = (sz == CIE_SZ_B) ? 8 : ((sz == CIE_SZ_W) ? 16 : 32);
		for (int i = 0; i < 64; i++)
		begin
			if (i < int'(cnt))
			begin
				if (left)
					r = ((r << 1) | 32'((r >> (w - 1)) & 32'h1)) & size_mask(sz);
				else
					r = (r >> 1) | ((r & 32'h1) << (w - 1));
			end
		end
		rotate = r & size_mask(sz);
	endfunction

	// Decimal negate of a packed two-digit byte, borrow taken from the extend bit.
	function automatic logic [8:0] bcd_neg(input logic [7:0] d, input logic x);
		logic [4:0] lo;
		logic [4:0] hi;
		logic b;
		lo = 5'h00 - {1'b0, d[3:0]} - {4'h0, x};
		b = lo[4];
		if (b)
			lo = lo - 5'h06;
		hi = 5'h00 - {1'b0, d[7:4]} - {4'h0, b};
		b = hi[4];
		if (b)
			hi = hi - 5'h06;
		bcd_neg = {b, hi[3:0], lo[3:0]};
	endfunction

	function automatic logic [3:0] first_set(input logic [15:0] l);
		first_set = 4'h0;
		for (int i = 15; i >= 0; i--)
		begin
			if (l[i])
				first_set = 4'(i);
		end
	endfunction

	assign supv = sr_ff[CIE_SR_S_BIT];
	always_comb
	begin
		unique case (op_code)
			CIE_OP_SR_STORE, CIE_OP_SR_LOAD, CIE_OP_USP_TO_AREG, CIE_OP_AREG_TO_USP,
			CIE_OP_CTRL_TO_GREG, CIE_OP_GREG_TO_CTRL, CIE_OP_ALT_WRITE, CIE_OP_ALT_READ,
			CIE_OP_ORI_SR, CIE_OP_RESET: priv_op = 1'b1;
			default: priv_op = 1'b0;
		endcase
	end

	always_comb
	begin
		logic [63:0] prod;
		logic [31:0] mask, tmp;
		logic [8:0] bn;
		logic [3:0] idx;
		logic x;
		prod = 64'h0;
		mask = size_mask(op_size);
		tmp = 32'h0;
		bn = 9'h0;
		idx = 4'h0;
		x = sr_ff[CIE_CCR_X_BIT];
		nxt_state = state_ff;
		nxt_sr = sr_ff;
		nxt_usp = usp_ff;
		nxt_ssp = ssp_ff;
		nxt_vbr = vbr_ff;
		nxt_sfc = sfc_ff;
		nxt_dfc = dfc_ff;
		nxt_list = list_ff;
		nxt_mreg_load = mreg_load_ff;
		nxt_rst_cnt = rst_cnt_ff;
		nxt_res_valid = 1'b0;
		nxt_res_trap = 1'b0;
		nxt_res_hi = 1'b0;
		nxt_res_data = res_data_ff;
		nxt_res_hi_data = res_hi_data_ff;
		nxt_mem_we = 1'b0;
		nxt_mem_re = 1'b0;
		nxt_mem_addr = mem_addr_ff;
		nxt_mem_wdata = mem_wdata_ff;
		nxt_mem_fc = mem_fc_ff;
		nxt_mem_idx = mem_idx_ff;
		unique case (state_ff)
			CIE_ST_IDLE:
			begin
				if (op_valid && priv_op && !supv)
				begin
					nxt_res_valid = 1'b1;
					nxt_res_trap = 1'b1;
				end
				else if (op_valid)
				begin
					nxt_res_valid = 1'b1;
					unique case (op_code)
						CIE_OP_CCR_LOAD: nxt_sr = {sr_ff[15:8], op_src[7:0]};
						CIE_OP_SR_STORE: nxt_res_data = {16'h0000, sr_ff};
						CIE_OP_SR_LOAD: nxt_sr = op_src[15:0];
						CIE_OP_USP_TO_AREG: nxt_res_data = usp_ff;
						CIE_OP_AREG_TO_USP: nxt_usp = op_src;
						CIE_OP_CTRL_TO_GREG:
						begin
							unique case (op_ctrl_sel)
								CIE_CR_SFC: nxt_res_data = {29'h0, sfc_ff};
								CIE_CR_DFC: nxt_res_data = {29'h0, dfc_ff};
								CIE_CR_USP: nxt_res_data = usp_ff;
								CIE_CR_VBR: nxt_res_data = vbr_ff;
								default: nxt_res_data = 32'h00000000;
							endcase
						end
						CIE_OP_GREG_TO_CTRL:
						begin
							unique case (op_ctrl_sel)
								CIE_CR_SFC: nxt_sfc = op_src[2:0];
								CIE_CR_DFC: nxt_dfc = op_src[2:0];
								CIE_CR_USP: nxt_usp = op_src;
								CIE_CR_VBR: nxt_vbr = op_src;
								default: nxt_vbr = vbr_ff;
							endcase
						end
						CIE_OP_ALT_WRITE:
						begin
							nxt_mem_we = 1'b1;
							nxt_mem_addr = op_addr;
							nxt_mem_wdata = op_src & mask;
							nxt_mem_fc = dfc_ff;
						end
						CIE_OP_ALT_READ:
						begin
							nxt_mem_re = 1'b1;
							nxt_mem_addr = op_addr;
							nxt_mem_fc = sfc_ff;
						end
						CIE_OP_SIGNED_MULTIPLY, CIE_OP_UNSIGNED_MULTIPLY:
						begin
							unique case (op_mul_form)
								CIE_MUL_W:
								begin
									if (op_code == CIE_OP_SIGNED_MULTIPLY)
										prod = 64'($signed(op_src[15:0]) * $signed(op_dst[15:0]));
									else
										prod = 64'(op_src[15:0] * op_dst[15:0]);
								end
								default:
								begin
									if (op_code == CIE_OP_SIGNED_MULTIPLY)
										prod = $signed(op_src) * $signed(op_dst);
									else
										prod = {32'h0, op_src} * {32'h0, op_dst};
								end
							endcase
							nxt_res_data = prod[31:0];
							nxt_res_hi_data = prod[63:32];
							nxt_res_hi = (op_mul_form == CIE_MUL_L64);
						end
						CIE_OP_DECIMAL_NEGATE:
						begin
							bn = bcd_neg(op_dst[7:0], x);
							nxt_res_data = {op_dst[31:8], bn[7:0]};
							nxt_sr = {sr_ff[15:5], bn[8], sr_ff[3:1], bn[8]};
						end
						CIE_OP_NEG: nxt_res_data = merge(op_dst, 32'h0 - op_dst, op_size);
						CIE_OP_INVERT_WITH_BORROW:
							nxt_res_data = merge(op_dst, 32'h0 - op_dst - {31'h0, x}, op_size);
						CIE_OP_OR: nxt_res_data = merge(op_dst, op_src | op_dst, op_size);
						CIE_OP_ORI: nxt_res_data = merge(op_dst, op_imm | op_dst, op_size);
						CIE_OP_ORI_CCR: nxt_sr = sr_ff | {8'h00, op_imm[7:0]};
						CIE_OP_ORI_SR: nxt_sr = sr_ff | op_imm[15:0];
						CIE_OP_PEA:
						begin
							tmp = (supv ? ssp_ff : usp_ff) - CIE_PEA_STEP;
							if (supv)
								nxt_ssp = tmp;
							else
								nxt_usp = tmp;
							nxt_mem_we = 1'b1;
							nxt_mem_addr = tmp;
							nxt_mem_wdata = op_addr;
							nxt_mem_fc = supv ? 3'h5 : 3'h1;
							nxt_res_data = tmp;
						end
						CIE_OP_RESET:
						begin
							nxt_res_valid = 1'b0;
							nxt_rst_cnt = CIE_RESET_CNT;
							nxt_state = CIE_ST_RESET;
						end
						CIE_OP_QUICK: nxt_res_data = {{24{op_imm[7]}}, op_imm[7:0]};
						CIE_OP_MREG_STORE, CIE_OP_MREG_LOAD:
						begin
							nxt_res_valid = (op_reg_list == 16'h0000);
							nxt_list = op_reg_list;
							nxt_mreg_load = (op_code == CIE_OP_MREG_LOAD);
							nxt_mem_addr = op_addr - CIE_MREG_STEP;
							if (op_reg_list != 16'h0000)
								nxt_state = CIE_ST_MREG;
						end
						CIE_OP_ROL, CIE_OP_ROR:
							nxt_res_data = merge(op_dst, rotate(op_dst, op_imm[5:0], op_size,
								op_code == CIE_OP_ROL), op_size);
						default: nxt_res_data = res_data_ff;
					endcase
				end
			end
			CIE_ST_MREG:
			begin
				// One register per cycle; the caller supplies the register value on op_src.
				idx = first_set(list_ff);
				nxt_mem_idx = idx;
				nxt_mem_addr = mem_addr_ff + CIE_MREG_STEP;
				nxt_mem_we = !mreg_load_ff;
				nxt_mem_re = mreg_load_ff;
				nxt_mem_wdata = op_src;
				nxt_mem_fc = supv ? 3'h5 : 3'h1;
				nxt_list = list_ff & ~(16'h0001 << idx);
				if (nxt_list == 16'h0000)
				begin
					nxt_res_valid = 1'b1;
					nxt_state = CIE_ST_IDLE;
				end
			end
			CIE_ST_RESET:
			begin
				nxt_rst_cnt = rst_cnt_ff - 8'h01;
				if (rst_cnt_ff == 8'h01)
				begin
					nxt_res_valid = 1'b1;
					nxt_state = CIE_ST_IDLE;
				end
			end
			default: nxt_state = CIE_ST_IDLE;
		endcase
		// Software writes land after instruction effects so they win a same-cycle race.
		if (reg_we)
		begin
			unique case (reg_addr)
				CIE_ADR_SR: nxt_sr = reg_wdata[15:0];
				CIE_ADR_USP: nxt_usp = reg_wdata;
				CIE_ADR_SFC: nxt_sfc = reg_wdata[2:0];
				CIE_ADR_DFC: nxt_dfc = reg_wdata[2:0];
				CIE_ADR_VBR: nxt_vbr = reg_wdata;
				CIE_ADR_SSP: nxt_ssp = reg_wdata;
				default: nxt_vbr = nxt_vbr;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state_ff <= CIE_ST_IDLE;
			sr_ff <= CIE_SR_RST;
			usp_ff <= CIE_USP_RST;
			ssp_ff <= CIE_SSP_RST;
			vbr_ff <= 32'h00000000;
			sfc_ff <= CIE_SFC_RST;
			dfc_ff <= CIE_DFC_RST;
			list_ff <= 16'h0000;
			mreg_load_ff <= 1'b0;
			rst_cnt_ff <= 8'h00;
			res_valid_ff <= 1'b0;
			res_trap_ff <= 1'b0;
			res_hi_ff <= 1'b0;
			res_data_ff <= 32'h00000000;
			res_hi_data_ff <= 32'h00000000;
			mem_we_ff <= 1'b0;
			mem_re_ff <= 1'b0;
			mem_addr_ff <= 32'h00000000;
			mem_wdata_ff <= 32'h00000000;
			mem_fc_ff <= 3'h0;
			mem_idx_ff <= 4'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			sr_ff <= nxt_sr;
			usp_ff <= nxt_usp;
			ssp_ff <= nxt_ssp;
			vbr_ff <= nxt_vbr;
			sfc_ff <= nxt_sfc;
			dfc_ff <= nxt_dfc;
			list_ff <= nxt_list;
			mreg_load_ff <= nxt_mreg_load;
			rst_cnt_ff <= nxt_rst_cnt;
			res_valid_ff <= nxt_res_valid;
			res_trap_ff <= nxt_res_trap;
			res_hi_ff <= nxt_res_hi;
			res_data_ff <= nxt_res_data;
			res_hi_data_ff <= nxt_res_hi_data;
			mem_we_ff <= nxt_mem_we;
			mem_re_ff <= nxt_mem_re;
			mem_addr_ff <= nxt_mem_addr;
			mem_wdata_ff <= nxt_mem_wdata;
			mem_fc_ff <= nxt_mem_fc;
			mem_idx_ff <= nxt_mem_idx;
		end
	end

	// Interrupt status: a new event beats the clear-on-read of the same cycle.
	assign events[CIE_IRQ_TRAP] = nxt_res_trap;
	assign events[CIE_IRQ_DONE] = nxt_res_valid && !nxt_res_trap;
	assign events[CIE_IRQ_RESET] = (state_ff == CIE_ST_RESET) && (nxt_state == CIE_ST_IDLE);

	always_comb
	begin
		nxt_int_stat = int_stat_ff;
		nxt_int_mask = int_mask_ff;
		nxt_rdata = 32'h00000000;
		if (reg_re)
		begin
			unique case (reg_addr)
				CIE_ADR_STATUS:
				begin
					nxt_rdata = {29'h0, int_stat_ff};
					nxt_int_stat = 3'h0;
				end
				CIE_ADR_SR: nxt_rdata = {16'h0000, sr_ff};
				CIE_ADR_USP: nxt_rdata = usp_ff;
				CIE_ADR_MASK: nxt_rdata = {29'h0, int_mask_ff};
				CIE_ADR_SFC: nxt_rdata = {29'h0, sfc_ff};
				CIE_ADR_DFC: nxt_rdata = {29'h0, dfc_ff};
				CIE_ADR_VBR: nxt_rdata = vbr_ff;
				CIE_ADR_SSP: nxt_rdata = ssp_ff;
				default: nxt_rdata = 32'h00000000;
			endcase
		end
		if (reg_we && reg_addr == CIE_ADR_MASK)
			nxt_int_mask = reg_wdata[2:0];
		nxt_int_stat = nxt_int_stat | events;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			int_stat_ff <= CIE_INT_RST;
			int_mask_ff <= CIE_INT_RST;
			rdata_ff <= 32'h00000000;
		end
		else
		begin
			int_stat_ff <= nxt_int_stat;
			int_mask_ff <= nxt_int_mask;
			rdata_ff <= nxt_rdata;
		end
	end

	assign op_busy = (state_ff != CIE_ST_IDLE);
	assign res_valid = res_valid_ff;
	assign res_trap = res_trap_ff;
	assign res_data = res_data_ff;
	assign res_data_hi = res_hi_data_ff;
	assign res_hi_valid = res_hi_ff;
	assign mem_we = mem_we_ff;
	assign mem_re = mem_re_ff;
	assign mem_addr = mem_addr_ff;
	assign mem_wdata = mem_wdata_ff;
	assign mem_fc = mem_fc_ff;
	assign mem_reg_idx = mem_idx_ff;
	assign ext_reset_n = !(state_ff == CIE_ST_RESET);
	assign reg_rdata = rdata_ff;
	assign irq = |(int_stat_ff & int_mask_ff);
endmodule
`default_nettype wire

// file: tb/cie_exec_assertions.sv
// Concurrent checks on the ports of the instruction slice execution unit.
`timescale 1ns/10ps
`default_nettype none
module cie_exec_assertions
	import cie_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic op_valid,
	input var cie_op_t op_code,
	input var cie_size_t op_size,
	input var cie_mul_t op_mul_form,
	input wire logic [31:0] op_src,
	input wire logic [15:0] op_reg_list,
	input wire logic [31:0] op_addr,
	input wire logic op_busy,
	input wire logic res_valid,
	input wire logic res_hi_valid,
	input wire logic res_trap,
	input wire logic mem_we,
	input wire logic mem_re,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic ext_reset_n
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	logic take;
	assign take = op_valid && !op_busy;
	property p_trap_clean;
		res_trap |-> res_valid && !mem_we && !mem_re && ext_reset_n;
	endproperty
	a_trap_clean: assert property (p_trap_clean) else $error("trap with side effect");
	property p_ori_next;
		take && op_code == CIE_OP_ORI |=> res_valid && !res_trap;
	endproperty
	a_ori_next: assert property (p_ori_next) else $error("immediate or not done");
	property p_pea_push;
		take && op_code == CIE_OP_PEA |=> mem_we && mem_wdata == $past(op_addr);
	endproperty
	a_pea_push: assert property (p_pea_push) else $error("push stored wrong value");
	property p_mul_pair;
		take && op_code inside {CIE_OP_SIGNED_MULTIPLY, CIE_OP_UNSIGNED_MULTIPLY} && op_mul_form == CIE_MUL_L64
			|=> res_valid && res_hi_valid;
	endproperty
	a_mul_pair: assert property (p_mul_pair) else $error("long product lacks high word");
	property p_mul_short;
		take && op_code inside {CIE_OP_SIGNED_MULTIPLY, CIE_OP_UNSIGNED_MULTIPLY} && op_mul_form != CIE_MUL_L64
			|=> !res_hi_valid;
	endproperty
	a_mul_short: assert property (p_mul_short) else $error("short product gave high word");
	// The list is latched on the accepting edge, so the first transfer appears one cycle later.
	property p_mreg_walk;
		take && op_code == CIE_OP_MREG_STORE && op_reg_list == 16'h8001 |=>
			!mem_we ##1
			mem_we && mem_addr == $past(op_addr, 2) ##1
			mem_we && mem_addr == $past(op_addr, 3) + 32'h00000004 && res_valid;
	endproperty
	a_mreg_walk: assert property (p_mreg_walk) else $error("register list walk wrong");
	property p_reset_hold;
		$fell(ext_reset_n) |-> (!ext_reset_n && op_busy) [*8];
	endproperty
	a_reset_hold: assert property (p_reset_hold) else $error("reset output too short");
	property p_reset_end;
		$rose(ext_reset_n) |-> ##[0:1] res_valid;
	endproperty
	a_reset_end: assert property (p_reset_end) else $error("reset end not reported");
	property p_reset_start;
		take && op_code == CIE_OP_RESET |=> res_trap || !ext_reset_n;
	endproperty
	a_reset_start: assert property (p_reset_start) else $error("reset output not driven");
	// A byte or word transfer carries only the low part of the register.
	property p_alt_write;
		take && op_code == CIE_OP_ALT_WRITE |=> res_trap || (mem_we && mem_wdata ==
			($past(op_src) & (($past(op_size) == CIE_SZ_B) ? 32'h000000FF :
			(($past(op_size) == CIE_SZ_W) ? 32'h0000FFFF : 32'hFFFFFFFF))));
	endproperty
	a_alt_write: assert property (p_alt_write) else $error("alternate write data wrong");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the instruction slice execution unit.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top;
	import cie_pkg::*;
	logic mclk = 1'b0, srst = 1'b1, op_valid = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
	cie_op_t op_code = CIE_OP_NOP;
	cie_size_t op_size = CIE_SZ_L;
	cie_mul_t op_mul_form = CIE_MUL_W;
	logic [31:0] op_src = '0, op_dst = '0, op_dst_hi = '0, op_imm = '0, op_addr = '0, reg_wdata = '0;
	logic [11:0] op_ctrl_sel = '0;
	logic [15:0] op_reg_list = '0;
	logic [3:0] reg_addr = '0, mem_reg_idx;
	logic op_busy, res_valid, res_hi_valid, res_trap, mem_we, mem_re, ext_reset_n, irq;
	logic [31:0] res_data, res_data_hi, mem_addr, mem_wdata, reg_rdata, u, w, sp, s, d, im;
	logic [2:0] mem_fc;
	logic [63:0] e;
	logic x;
	cie_mul_t f;
	int failures = 0, n_tests = 0, cyc = 0, n, seed = 32'hF99A;
	cie_op_t ar[10] = '{CIE_OP_SIGNED_MULTIPLY, CIE_OP_UNSIGNED_MULTIPLY, CIE_OP_DECIMAL_NEGATE, CIE_OP_NEG, CIE_OP_INVERT_WITH_BORROW,
		CIE_OP_OR, CIE_OP_ORI, CIE_OP_QUICK, CIE_OP_ROL, CIE_OP_ROR};
	cie_op_t pv[10] = '{CIE_OP_SR_STORE, CIE_OP_SR_LOAD, CIE_OP_USP_TO_AREG, CIE_OP_AREG_TO_USP,
		CIE_OP_CTRL_TO_GREG, CIE_OP_GREG_TO_CTRL, CIE_OP_ALT_WRITE, CIE_OP_ALT_READ,
		CIE_OP_ORI_SR, CIE_OP_RESET};
	cie_op_t mr[2] = '{CIE_OP_MREG_STORE, CIE_OP_MREG_LOAD};
	cie_exec cie_exec_i (.mclk, .srst, .op_valid, .op_code, .op_size, .op_mul_form, .op_src,
		.op_dst, .op_dst_hi, .op_imm, .op_ctrl_sel, .op_reg_list, .op_addr, .op_busy, .res_valid,
		.res_data, .res_data_hi, .res_hi_valid, .res_trap, .mem_we, .mem_re, .mem_addr,
		.mem_wdata, .mem_fc, .mem_reg_idx, .ext_reset_n, .reg_addr, .reg_wdata, .reg_we,
		.reg_re, .reg_rdata, .irq);
	initial
	begin
		forever #5 mclk = ~mclk;
	end
	// Reference results worked out with plain arithmetic, independent of the design.
	function automatic logic [63:0] model(input cie_op_t c, input cie_mul_t mf,
		input logic [31:0] a, b, k, input logic bx);
		logic signed [63:0] p;
		int v;
		v = 100 - (b[7:4] * 10 + b[3:0] + bx);
		case (c)
			CIE_OP_SIGNED_MULTIPLY: p = (mf == CIE_MUL_W) ? $signed(a[15:0]) * $signed(b[15:0])
				: $signed(a) * $signed(b);
			CIE_OP_UNSIGNED_MULTIPLY: p = (mf == CIE_MUL_W) ? a[15:0] * b[15:0] : a * b;
			CIE_OP_DECIMAL_NEGATE: p = {32'h0, b[31:8], 4'(v % 100 / 10), 4'(v % 10)};
			CIE_OP_NEG: p = {32'h0, 32'h0 - b};
			CIE_OP_INVERT_WITH_BORROW: p = {32'h0, 32'h0 - b - 32'(bx)};
			CIE_OP_OR: p = {32'h0, a | b};
			CIE_OP_ORI: p = {32'h0, k | b};
			CIE_OP_QUICK: p = {32'h0, {24{k[7]}}, k[7:0]};
			CIE_OP_ROL: p = {32'h0, (b << k[4:0]) | (b >> (6'd32 - k[4:0]))};
			CIE_OP_ROR: p = {32'h0, (b >> k[4:0]) | (b << (6'd32 - k[4:0]))};
			default: p = '0;
		endcase
		return p;
	endfunction
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic go(input cie_op_t c, input logic tr);
		@(posedge mclk);
		op_valid <= 1'b1;
		op_code <= c;
		@(posedge mclk);
		op_valid <= 1'b0;
		#1;
		`CHK(res_trap, tr)
		if (tr || !(c inside {CIE_OP_RESET, CIE_OP_MREG_STORE, CIE_OP_MREG_LOAD}))
			`CHK(res_valid, 1'b1)
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] ex);
		@(posedge mclk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_re <= 1'b0;
		#1;
		`CHK(reg_rdata, ex)
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_we <= 1'b0;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			give_verdict;
		end
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		u = $random(seed);
		w = $random(seed);
		sp = CIE_SSP_RST - CIE_PEA_STEP;
		rd(CIE_ADR_SR, 32'h00002700);
		wr(4'hF, 32'hFFFFFFFF);
		rd(4'hF, 32'h0);
		op_size <= CIE_SZ_W;
		go(CIE_OP_SR_STORE, 1'b0);
		`CHK(res_data, 32'h00002700)
		op_src <= u;
		go(CIE_OP_AREG_TO_USP, 1'b0);
		go(CIE_OP_USP_TO_AREG, 1'b0);
		`CHK(res_data, u)
		op_ctrl_sel <= CIE_CR_VBR;
		op_src <= w;
		go(CIE_OP_GREG_TO_CTRL, 1'b0);
		go(CIE_OP_CTRL_TO_GREG, 1'b0);
		`CHK(res_data, w)
		op_ctrl_sel <= CIE_CR_DFC;
		op_src <= 32'h5;
		go(CIE_OP_GREG_TO_CTRL, 1'b0);
		rd(CIE_ADR_DFC, 32'h5);
		op_src <= u;
		op_addr <= w;
		go(CIE_OP_ALT_WRITE, 1'b0);
		`CHK({mem_we, mem_fc, mem_addr, mem_wdata}, {1'b1, 3'h5, w, u & 32'h0000FFFF})
		go(CIE_OP_ALT_READ, 1'b0);
		`CHK({mem_re, mem_fc}, {1'b1, CIE_SFC_RST})
		go(CIE_OP_PEA, 1'b0);
		`CHK({mem_we, mem_addr, mem_wdata, res_data}, {1'b1, sp, w, sp})
		rd(CIE_ADR_SSP, sp);
		op_reg_list <= 16'h8001;
		foreach (mr[i])
		begin
			go(mr[i], 1'b0);
			`CHK({mem_we, mem_re, op_busy}, 3'b001)
			@(posedge mclk);
			#1;
			`CHK({mem_we, mem_re, mem_reg_idx, mem_addr}, {~i[0], i[0], 4'h0, w})
			@(posedge mclk);
			#1;
			`CHK({mem_we, mem_re, mem_reg_idx, mem_addr, res_valid},
				{~i[0], i[0], 4'hF, w + 32'h4, 1'b1})
		end
		op_imm <= 32'h1F;
		go(CIE_OP_ORI_SR, 1'b0);
		rd(CIE_ADR_SR, 32'h0000271F);
		go(CIE_OP_RESET, 1'b0);
		n = 0;
		while (ext_reset_n === 1'b0 && n < 200)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		`CHK(n, CIE_RESET_CYCLES)
		`CHK(res_valid, 1'b1)
		foreach (ar[k])
			for (int j = 0; j < 12; j++)
			begin
				s = $random(seed);
				d = $random(seed);
				im = $random(seed);
				x = s[9];
				f = cie_mul_t'(j % 3);
				if (ar[k] == CIE_OP_DECIMAL_NEGATE)
					d[7:0] = {4'(d[7:4] % 10), 4'(d[3:0] % 10)};
				// The borrow bit is loaded first so every extended result is predictable.
				op_src <= {27'h0, x, 4'h0};
				go(CIE_OP_CCR_LOAD, 1'b0);
				op_src <= s;
				op_dst <= d;
				op_imm <= im;
				op_mul_form <= f;
				op_size <= (ar[k] == CIE_OP_DECIMAL_NEGATE) ? CIE_SZ_B : CIE_SZ_L;
				e = model(ar[k], f, s, d, im, x);
				go(ar[k], 1'b0);
				`CHK(res_data, e[31:0])
				if (f == CIE_MUL_L64 && ar[k] inside {CIE_OP_SIGNED_MULTIPLY, CIE_OP_UNSIGNED_MULTIPLY})
					`CHK({res_hi_valid, res_data_hi}, {1'b1, e[63:32]})
			end
		`CHK(irq, 1'b0)
		rd(CIE_ADR_STATUS, 32'h6);
		op_src <= '0;
		go(CIE_OP_SR_LOAD, 1'b0);
		op_src <= '1;
		op_imm <= '1;
		foreach (pv[i])
		begin
			go(pv[i], 1'b1);
			`CHK({mem_we, mem_re, ext_reset_n}, 3'b001)
		end
		rd(CIE_ADR_SR, 32'h0);
		rd(CIE_ADR_USP, u);
		`CHK(irq, 1'b0)
		wr(CIE_ADR_MASK, 32'h1);
		#1;
		`CHK(irq, 1'b1)
		rd(CIE_ADR_STATUS, 32'h3);
		`CHK(irq, 1'b0)
		op_imm <= 32'h11;
		go(CIE_OP_ORI_CCR, 1'b0);
		rd(CIE_ADR_SR, 32'h11);
		give_verdict;
	end
endmodule
bind cie_exec cie_exec_assertions cie_exec_assertions_i (.mclk, .srst, .op_valid, .op_code,
	.op_size, .op_mul_form, .op_src, .op_reg_list, .op_addr, .op_busy, .res_valid, .res_hi_valid,
	.res_trap, .mem_we, .mem_re, .mem_addr, .mem_wdata, .ext_reset_n);
`default_nettype wire
